// File: hdl/abc_consts.svh
// Purpose: offsets, field positions and reset values of the register bank
// Assumes: word addresses on a 7-bit local byte address
// Notes: definitions only
`ifndef ABC_CONSTS_SVH
`define ABC_CONSTS_SVH
`define ABC_OFS_BCR 7'h00
`define ABC_OFS_RATE_A 7'h04
`define ABC_OFS_RATE_B 7'h08
`define ABC_OFS_GRP_SRC 7'h0c
`define ABC_OFS_DIV 7'h10
`define ABC_OFS_SPARE 7'h14
`define ABC_OFS_PLL 7'h18
`define ABC_OFS_GPS 7'h1c
`define ABC_OFS_BUFCTL 7'h20
`define ABC_OFS_OPTIONS 7'h24
`define ABC_OFS_FILL 7'h28
`define ABC_OFS_CALVAL 7'h2c
`define ABC_OFS_DATA 7'h30
`define ABC_RST_BCR 32'h0000383c
`define ABC_RST_RATE 32'h00400032
`define ABC_RST_GRP_SRC 32'h00000000
`define ABC_RST_DIV 32'h00000505
`define ABC_RST_GPS 32'h00002000
`define ABC_RST_THR 18'h3fffe
`define ABC_BCR_MODE 0
`define ABC_BCR_SPAN 2
`define ABC_BCR_FMT 4
`define ABC_BCR_INIT 5
`define ABC_BCR_SYNC 6
`define ABC_BCR_CAL 7
`define ABC_BCR_IRQSEL 8
`define ABC_BCR_IRQF 11
`define ABC_BCR_PASS 12
`define ABC_BCR_RDY 13
`define ABC_BCR_THR 14
`define ABC_BUF_FULL 24
`define ABC_THR_W 18
`endif

// File: hdl/abc_pkg.sv
// Purpose: types shared by the register bank files
// Assumes: nothing
// Notes: offsets live in abc_consts.svh
package abc_pkg;
   typedef struct packed
   {
      logic [1:0] mode;
      logic [1:0] span;
      logic offset_binary;
      logic initiator;
      logic [2:0] irq_sel;
   } abc_ctl_s;
   typedef struct packed
   {
      logic [31:0] rate_a;
      logic [31:0] rate_b;
      logic [31:0] group_src;
      logic [31:0] divisors;
      logic [31:0] gps;
   } abc_rate_s;
   typedef enum logic [1:0]
   {
      ABC_CAL_IDLE = 2'b00,
      ABC_CAL_RUN = 2'b01
   } abc_cal_e;
endpackage

// File: hdl/abc_sample_fifo.sv
// Purpose: input sample buffer with fill count and full flag
// Assumes: one clock, synchronous reset
// Notes: head word is read combinationally; the caller registers it
`timescale 1ns/1ps
`default_nettype none
module abc_sample_fifo
#(
   parameter int W = 32,
   parameter int AW = 18
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic wr_valid,
   input wire logic [W-1:0] wr_data,
   output logic wr_ready,
   input wire logic rd_pop,
   output logic [W-1:0] rd_data,
   output logic [AW:0] count,
   output logic full
);
   localparam logic [AW:0] DEPTH = (AW+1)'(2**AW);
   logic [W-1:0] mem [0:(2**AW)-1];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_next;
   logic push;
   logic pop;

   assign push = wr_valid & wr_ready;
   assign pop = rd_pop & (count != '0);
   assign count_next = count + (AW+1)'(push) - (AW+1)'(pop);
   assign rd_data = mem[rd_ptr_reg];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= wr_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count <= '0;
         full <= 1'b0;
         wr_ready <= 1'b1;
      end
      else
      begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count <= count_next;
         // ready from the next count keeps a write from landing when full
         full <= (count_next == DEPTH);
         wr_ready <= (count_next != DEPTH);
      end
   end
endmodule
`default_nettype wire

// File: hdl/abc_regs.sv
// Purpose: board control register bank of the analog input board
// Assumes: local bus from the host bridge, one access per strobe
// Notes: Operation list follows
// Operation
// - every host access is a full 32-bit word; byte lanes are not decoded
// - reserved bits ignore writes and read back as zero
// - offsets decoded from the local base, data buffer at 30h, above reserved
// - board control resets to 383Ch and reads 783Ch when buffer full
// - buffer control resets to 0003FFFEh, reads 0103FFFEh when full
// - divisors default 0505h, rate controls 00400032h, assignments zero
// - GPS sync register is read/write, default 00002000h
// - read-only register reports the current buffer fill count
// - data register read returns tagged sample and removes it
// - bits 1:0 choose system inputs or selftest, default system
// - bits 3:2 choose input range, default ten volt range
// - bit 4 selects offset binary when set, two's complement when clear
// - bit 5 selects initiator or target, default initiator
// - bit 6 starts a sync, drives external sync if initiator, self-clears
// - bit 7 starts autocalibration and clears when the run ends
// - bits 10:8 form the interrupt event selector, default zero
// - read-only register shows the reference frequency, no reset value
// - read-only options register, upper byte reads zero
// - register window fits any 32-word boundary of memory space
// - bit 14 reads one while buffer content exceeds the threshold
`timescale 1ns/1ps
`default_nettype none
`include "abc_consts.svh"
module abc_regs
   import abc_pkg::*;
#(
   parameter int FIFO_AW = 18
)
(
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic [6:0] LB_ADDR,
   input wire logic LB_WR,
   input wire logic LB_RD,
   input wire logic [31:0] LB_WDATA,
   output logic [31:0] LB_RDATA,
   output logic LB_ACK,
   input wire logic SAMPLE_VALID,
   input wire logic [31:0] SAMPLE_WORD,
   output logic SAMPLE_READY,
   input wire logic CAL_DONE,
   input wire logic CAL_FAIL,
   input wire logic [31:0] CAL_VALUE,
   input wire logic [31:0] PLL_FREQ,
   input wire logic [23:0] OPTIONS,
   output abc_ctl_s CTL,
   output abc_rate_s RATE_CFG,
   output logic SYNC_PULSE,
   output logic EXT_SYNC_OUT,
   output logic CAL_START
);

////////////////////////////////////////////////////////////////////////////////
   logic [4:0] word;
   logic wr_bcr;
   logic rd_data_port;
   logic sync_reg;
   logic irq_flag_reg;
   logic cal_pass_reg;
   abc_cal_e cal_reg;
   abc_cal_e cal_next;
   logic [`ABC_THR_W-1:0] thr_reg;
   logic [31:0] rdata_next;
   logic [31:0] head;
   logic [FIFO_AW:0] fill;
   logic buf_full;
   logic thr_hit;

   function automatic logic hit(input logic [6:0] ofs);
      hit = (word == ofs[6:2]);
   endfunction

   // low address bits are ignored: word-only access
   // word access
   assign word = LB_ADDR[6:2];
   // direct compares: a continuous assign does not wake on what a function reads inside
   assign wr_bcr = LB_WR & (word == 5'(`ABC_OFS_BCR >> 2));
   assign rd_data_port = LB_RD & (word == 5'(`ABC_OFS_DATA >> 2));
   assign thr_hit = (32'(fill) > 32'(thr_reg));

////////////////////////////////////////////////////////////////////////////////
// sample buffer

   abc_sample_fifo #(
      .W(32),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(REF_CLK),
      .srst(SRST),
      .wr_valid(SAMPLE_VALID),
      .wr_data(SAMPLE_WORD),
      .wr_ready(SAMPLE_READY),
      .rd_pop(rd_data_port),
      .rd_data(head),
      .count(fill),
      .full(buf_full)
   );

////////////////////////////////////////////////////////////////////////////////
// board control fields

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         CTL.mode <= 2'(`ABC_RST_BCR >> `ABC_BCR_MODE);
         CTL.span <= 2'(`ABC_RST_BCR >> `ABC_BCR_SPAN);
         CTL.offset_binary <= 1'(`ABC_RST_BCR >> `ABC_BCR_FMT);
         CTL.initiator <= 1'(`ABC_RST_BCR >> `ABC_BCR_INIT);
         CTL.irq_sel <= 3'(`ABC_RST_BCR >> `ABC_BCR_IRQSEL);
         irq_flag_reg <= 1'(`ABC_RST_BCR >> `ABC_BCR_IRQF);
      end
      else if (wr_bcr)
      begin
         CTL.mode <= LB_WDATA[`ABC_BCR_MODE +: 2];
         CTL.span <= LB_WDATA[`ABC_BCR_SPAN +: 2];
         CTL.offset_binary <= LB_WDATA[`ABC_BCR_FMT];
         CTL.initiator <= LB_WDATA[`ABC_BCR_INIT];
         CTL.irq_sel <= LB_WDATA[`ABC_BCR_IRQSEL +: 3];
         irq_flag_reg <= LB_WDATA[`ABC_BCR_IRQF];
      end
   end

////////////////////////////////////////////////////////////////////////////////
// software sync

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         sync_reg <= 1'b0;
         SYNC_PULSE <= 1'b0;
         EXT_SYNC_OUT <= 1'b0;
      end
      else
      begin
         sync_reg <= wr_bcr & LB_WDATA[`ABC_BCR_SYNC];
         SYNC_PULSE <= wr_bcr & LB_WDATA[`ABC_BCR_SYNC];
         // external sync follows the mode being written in the same word
         EXT_SYNC_OUT <= wr_bcr & LB_WDATA[`ABC_BCR_SYNC] & LB_WDATA[`ABC_BCR_INIT];
      end
   end

////////////////////////////////////////////////////////////////////////////////
// autocalibration

   always_comb
   begin
      cal_next = cal_reg;
      unique case (cal_reg)
         ABC_CAL_IDLE:
         begin
            if (wr_bcr && LB_WDATA[`ABC_BCR_CAL])
            begin
               cal_next = ABC_CAL_RUN;
            end
         end
         ABC_CAL_RUN:
         begin
            if (CAL_DONE)
            begin
               cal_next = ABC_CAL_IDLE;
            end
         end
         default:
         begin
            cal_next = ABC_CAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         cal_reg <= ABC_CAL_IDLE;
         CAL_START <= 1'b0;
         cal_pass_reg <= 1'b1;
      end
      else
      begin
         cal_reg <= cal_next;
         CAL_START <= (cal_reg == ABC_CAL_IDLE) && (cal_next == ABC_CAL_RUN);
         if (CAL_START)
         begin
            cal_pass_reg <= 1'b1;
         end
         else if (cal_reg == ABC_CAL_RUN && CAL_DONE && CAL_FAIL)
         begin
            cal_pass_reg <= 1'b0;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// rate, divisor, gps and buffer control

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         RATE_CFG.rate_a <= `ABC_RST_RATE;
         RATE_CFG.rate_b <= `ABC_RST_RATE;
         RATE_CFG.group_src <= `ABC_RST_GRP_SRC;
         RATE_CFG.divisors <= `ABC_RST_DIV;
         RATE_CFG.gps <= `ABC_RST_GPS;
         thr_reg <= `ABC_RST_THR;
      end
      else if (LB_WR)
      begin
         if (hit(`ABC_OFS_RATE_A))
         begin
            RATE_CFG.rate_a <= LB_WDATA;
         end
         if (hit(`ABC_OFS_RATE_B))
         begin
            RATE_CFG.rate_b <= LB_WDATA;
         end
         if (hit(`ABC_OFS_GRP_SRC))
         begin
            RATE_CFG.group_src <= LB_WDATA;
         end
         if (hit(`ABC_OFS_DIV))
         begin
            RATE_CFG.divisors <= LB_WDATA;
         end
         if (hit(`ABC_OFS_GPS))
         begin
            RATE_CFG.gps <= LB_WDATA;
         end
         if (hit(`ABC_OFS_BUFCTL))
         begin
            thr_reg <= LB_WDATA[`ABC_THR_W-1:0];
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// read mux

   // read-only words have no write path
   always_comb
   begin
      rdata_next = '0;
      unique case (word)
         `ABC_OFS_BCR >> 2:
         begin
            rdata_next[`ABC_BCR_MODE +: 2] = CTL.mode;
            rdata_next[`ABC_BCR_SPAN +: 2] = CTL.span;
            rdata_next[`ABC_BCR_FMT] = CTL.offset_binary;
            rdata_next[`ABC_BCR_INIT] = CTL.initiator;
            rdata_next[`ABC_BCR_SYNC] = sync_reg;
            rdata_next[`ABC_BCR_CAL] = (cal_reg == ABC_CAL_RUN);
            rdata_next[`ABC_BCR_IRQSEL +: 3] = CTL.irq_sel;
            rdata_next[`ABC_BCR_IRQF] = irq_flag_reg;
            rdata_next[`ABC_BCR_PASS] = cal_pass_reg;
            rdata_next[`ABC_BCR_RDY] = (cal_reg == ABC_CAL_IDLE);
            rdata_next[`ABC_BCR_THR] = thr_hit;
         end
         `ABC_OFS_RATE_A >> 2: rdata_next = RATE_CFG.rate_a;
         `ABC_OFS_RATE_B >> 2: rdata_next = RATE_CFG.rate_b;
         `ABC_OFS_GRP_SRC >> 2: rdata_next = RATE_CFG.group_src;
         `ABC_OFS_DIV >> 2: rdata_next = RATE_CFG.divisors;
         `ABC_OFS_PLL >> 2: rdata_next = PLL_FREQ;
         `ABC_OFS_GPS >> 2: rdata_next = RATE_CFG.gps;
         `ABC_OFS_BUFCTL >> 2:
         begin
            rdata_next[`ABC_THR_W-1:0] = thr_reg;
            rdata_next[`ABC_BUF_FULL] = buf_full;
         end
         `ABC_OFS_OPTIONS >> 2: rdata_next[23:0] = OPTIONS;
         `ABC_OFS_FILL >> 2: rdata_next = 32'(fill);
         `ABC_OFS_CALVAL >> 2: rdata_next = CAL_VALUE;
         // empty buffer reads zero
         `ABC_OFS_DATA >> 2: rdata_next = (fill != '0) ? head : 32'h0;
         default: rdata_next = '0;
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (SRST)
      begin
         LB_RDATA <= '0;
         LB_ACK <= 1'b0;
      end
      else
      begin
         // 5-bit word index spans the 32-word window
         LB_ACK <= LB_RD | LB_WR;
         LB_RDATA <= LB_RD ? rdata_next : 32'h0;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// checks

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SRST);

   bus_ack_a: assert property ((LB_RD | LB_WR) |=> LB_ACK)
      else $error("access not acknowledged");

   spare_zero_a: assert property
      ((LB_RD && word == (`ABC_OFS_SPARE >> 2)) |=> LB_RDATA == 32'h0)
      else $error("spare word not zero");

   sync_clear_a: assert property
      (SYNC_PULSE == $past(wr_bcr && LB_WDATA[`ABC_BCR_SYNC]))
      else $error("sync not one cycle");

   ext_sync_a: assert property (EXT_SYNC_OUT |-> SYNC_PULSE && CTL.initiator)
      else $error("external sync outside initiator");

   cal_hold_a: assert property
      ((cal_reg == ABC_CAL_RUN && !CAL_DONE) |=> cal_reg == ABC_CAL_RUN)
      else $error("calibration ended early");

   thr_flag_a: assert property
      ((LB_RD && word == 5'h0) |=> LB_RDATA[`ABC_BCR_THR] == $past(thr_hit))
      else $error("threshold flag wrong");

   full_flag_a: assert property
      ((LB_RD && hit(`ABC_OFS_BUFCTL)) |=> LB_RDATA[`ABC_BUF_FULL] == $past(buf_full))
      else $error("full flag wrong");

   pop_count_a: assert property
      ((rd_data_port && fill != '0 && !(SAMPLE_VALID && SAMPLE_READY))
         |=> fill == $past(fill) - 1'b1)
      else $error("data read did not pop");

   opt_byte_a: assert property
      ((LB_RD && hit(`ABC_OFS_OPTIONS)) |=> LB_RDATA[31:24] == 8'h0)
      else $error("options upper byte not zero");

   cov_sync_c: cover property (EXT_SYNC_OUT);
   cov_cal_c: cover property (CAL_START ##[1:50] cal_reg == ABC_CAL_IDLE);
   cov_pop_c: cover property (rd_data_port && fill != '0);
endmodule
`default_nettype wire

// File: verification/abc_far_model.sv
// Purpose: far-side stand-in, a sample source and a calibration engine
// Assumes: drives its outputs on the falling edge of clk, except starts, which counts on the rising edge
// Notes: sample word carries tag 5ah in its top byte and a sequence number below
`timescale 1ns/1ps
`default_nettype none
module abc_far_model
#(
   parameter int CAL_DLY = 20
)
(
   input wire logic clk,
   input wire logic [7:0] quota,
   input wire logic fail_mode,
   input wire logic sample_ready,
   input wire logic cal_start,
   output logic sample_valid,
   output logic [31:0] sample_word,
   output logic cal_done,
   output logic cal_fail,
   output logic [7:0] starts
);
   logic [7:0] sent;
   logic [7:0] cal_cnt;
   initial
   begin
      sent = 8'h00;
      cal_cnt = 8'h00;
      starts = 8'h00;
      sample_valid = 1'b0;
      sample_word = 32'h00000000;
      cal_done = 1'b0;
      cal_fail = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // offer stays up while the block is full, a stalling source
   always @(negedge clk)
   begin
      sample_valid <= (sent < quota);
      sample_word <= {8'h5a, 16'h0000, sent};
      cal_done <= (cal_cnt == 8'h01);
      cal_fail <= (cal_cnt == 8'h01) && fail_mode;
   end
   always @(posedge clk)
   begin
      if (sample_valid && sample_ready)
         sent <= sent + 8'h01;
      if (cal_start)
      begin
         cal_cnt <= 8'(CAL_DLY);
         starts <= starts + 8'h01;
      end
      else if (cal_cnt != 8'h00)
         cal_cnt <= cal_cnt - 8'h01;
   end
endmodule
`default_nettype wire

// File: verification/adc_board_control_registers_tb.sv
// Purpose: self-checking bench of the board control register bank
// Assumes: buffer depth cut to 8 words through FIFO_AW
// Notes: one gap cycle between accesses, inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module adc_board_control_registers_tb
   import abc_pkg::*;
;
   localparam logic [31:0] PLL = 32'h1234abcd;
   localparam logic [23:0] OPT = 24'ha5c3e1;
   localparam logic [31:0] CALV = 32'h0f0e0d0c;
   logic REF_CLK, SRST, LB_WR, LB_RD, LB_ACK, SAMPLE_VALID, SAMPLE_READY;
   logic CAL_DONE, CAL_FAIL, SYNC_PULSE, EXT_SYNC_OUT, CAL_START, fail_mode;
   logic sync_seen, ext_seen;
   logic [6:0] LB_ADDR;
   logic [31:0] LB_WDATA, LB_RDATA, SAMPLE_WORD;
   logic [7:0] quota, starts;
   abc_ctl_s CTL;
   abc_rate_s RATE_CFG;
   int num_errors = 0;
   int cmp_count = 0;
   logic [6:0] rw_ofs [5] = '{7'h04, 7'h08, 7'h0c, 7'h10, 7'h1c};
   logic [6:0] ro_ofs [6] = '{7'h14, 7'h18, 7'h24, 7'h28, 7'h2c, 7'h30};
   abc_regs #(.FIFO_AW(3)) i_abc_regs (.REF_CLK(REF_CLK), .SRST(SRST),
      .LB_ADDR(LB_ADDR), .LB_WR(LB_WR), .LB_RD(LB_RD), .LB_WDATA(LB_WDATA),
      .LB_RDATA(LB_RDATA), .LB_ACK(LB_ACK), .SAMPLE_VALID(SAMPLE_VALID),
      .SAMPLE_WORD(SAMPLE_WORD), .SAMPLE_READY(SAMPLE_READY), .CAL_DONE(CAL_DONE),
      .CAL_FAIL(CAL_FAIL), .CAL_VALUE(CALV), .PLL_FREQ(PLL), .OPTIONS(OPT),
      .CTL(CTL), .RATE_CFG(RATE_CFG), .SYNC_PULSE(SYNC_PULSE),
      .EXT_SYNC_OUT(EXT_SYNC_OUT), .CAL_START(CAL_START));
   abc_far_model i_abc_far_model (.clk(REF_CLK), .quota(quota),
      .fail_mode(fail_mode), .sample_ready(SAMPLE_READY), .cal_start(CAL_START),
      .sample_valid(SAMPLE_VALID), .sample_word(SAMPLE_WORD),
      .cal_done(CAL_DONE), .cal_fail(CAL_FAIL), .starts(starts));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // strobe for one cycle, answer taken at the next falling edge
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(negedge REF_CLK);
      LB_ADDR = a;
      LB_WDATA = d;
      LB_WR = 1'b1;
      @(negedge REF_CLK);
      LB_WR = 1'b0;
      sync_seen = SYNC_PULSE;
      ext_seen = EXT_SYNC_OUT;
      chk("wr ack", {31'h0, LB_ACK}, 32'h1);
   endtask
   task automatic rc(input string nm, input logic [6:0] a, input logic [31:0] exp);
      @(negedge REF_CLK);
      LB_ADDR = a;
      LB_RD = 1'b1;
      @(negedge REF_CLK);
      LB_RD = 1'b0;
      chk("rd ack", {31'h0, LB_ACK}, 32'h1);
      chk(nm, LB_RDATA, exp);
   endtask
   task automatic results;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end
   initial
   begin
      #200000;
      num_errors++;
      results();
   end
   initial
   begin
      SRST = 1'b1;
      LB_WR = 1'b0;
      LB_RD = 1'b0;
      LB_ADDR = 7'h00;
      LB_WDATA = 32'h00000000;
      quota = 8'h00;
      fail_mode = 1'b0;
      repeat (4) @(posedge REF_CLK);
      @(negedge REF_CLK);
      SRST = 1'b0;
      rc("bcr rst", 7'h00, 32'h0000383c);
      chk("ctl rst", {23'h0, CTL}, 32'h00000078);
      rc("rate a", 7'h04, 32'h00400032);
      rc("rate b", 7'h08, 32'h00400032);
      rc("assign", 7'h0c, 32'h00000000);
      rc("divs", 7'h10, 32'h00000505);
      rc("gps", 7'h1c, 32'h00002000);
      rc("bufctl", 7'h20, 32'h0003fffe);
      chk("cfg div", RATE_CFG.divisors, 32'h00000505);
      for (int a = 'h34; a <= 'h7c; a += 4)
      begin
         wr(a[6:0], 32'hffffffff);
         rc("hole", a[6:0], 32'h00000000);
      end
      foreach (rw_ofs[i]) wr(rw_ofs[i], {25'h1a5c3e1, rw_ofs[i]});
      foreach (rw_ofs[i]) rc("rw", rw_ofs[i], {25'h1a5c3e1, rw_ofs[i]});
      chk("cfg gps", RATE_CFG.gps, {25'h1a5c3e1, 7'h1c});
      chk("cfg a", RATE_CFG.rate_a, {25'h1a5c3e1, 7'h04});
      chk("cfg b", RATE_CFG.rate_b, {25'h1a5c3e1, 7'h08});
      chk("cfg src", RATE_CFG.group_src, {25'h1a5c3e1, 7'h0c});
      foreach (ro_ofs[i]) wr(ro_ofs[i], 32'hffffffff);
      rc("spare", 7'h14, 32'h00000000);
      rc("pll", 7'h18, PLL);
      rc("opts", 7'h24, {8'h00, OPT});
      rc("fill", 7'h28, 32'h00000000);
      rc("calv", 7'h2c, CALV);
      rc("empty", 7'h30, 32'h00000000);
      // every field set, start bits left clear
      wr(7'h00, 32'hffffff3f);
      rc("bcr ones", 7'h00, 32'h00003f3f);
      chk("ctl ones", {23'h0, CTL}, 32'h000001ff);
      chk("no sync", {31'h0, sync_seen}, 32'h0);
      wr(7'h00, 32'h00000000);
      rc("bcr zero", 7'h00, 32'h00003000);
      chk("ctl zero", {23'h0, CTL}, 32'h00000000);
      wr(7'h00, 32'h0000007c);
      chk("sync", {30'h0, sync_seen, ext_seen}, 32'h3);
      rc("sync clr", 7'h00, 32'h0000303c);
      wr(7'h00, 32'h0000005c);
      chk("sync tgt", {30'h0, sync_seen, ext_seen}, 32'h2);
      // failing run first, so the pass flag is seen to come back
      fail_mode = 1'b1;
      wr(7'h00, 32'h000000bc);
      rc("cal run", 7'h00, 32'h000010bc);
      chk("starts", {24'h0, starts}, 32'h1);
      repeat (30) @(negedge REF_CLK);
      rc("cal fail", 7'h00, 32'h0000203c);
      fail_mode = 1'b0;
      wr(7'h00, 32'h000000bc);
      repeat (30) @(negedge REF_CLK);
      rc("cal pass", 7'h00, 32'h0000303c);
      chk("starts", {24'h0, starts}, 32'h2);
      wr(7'h00, 32'h0000383c);
      wr(7'h20, 32'hffffffff);
      rc("thr ones", 7'h20, 32'h0003ffff);
      wr(7'h20, 32'h00000005);
      quota = 8'd5;
      repeat (10) @(negedge REF_CLK);
      rc("fill 5", 7'h28, 32'h00000005);
      rc("thr eq", 7'h00, 32'h0000383c);
      quota = 8'd6;
      repeat (4) @(negedge REF_CLK);
      rc("fill 6", 7'h28, 32'h00000006);
      rc("thr over", 7'h00, 32'h0000783c);
      wr(7'h20, 32'h0003fffe);
      rc("thr dflt", 7'h00, 32'h0000383c);
      // one offer more than fits, it must wait and not be lost
      quota = 8'd9;
      repeat (10) @(negedge REF_CLK);
      rc("fill 8", 7'h28, 32'h00000008);
      chk("ready", {31'h0, SAMPLE_READY}, 32'h0);
      rc("buf full", 7'h20, 32'h0103fffe);
      // eight words never pass the default threshold, so it drops to depth less one
      wr(7'h20, 32'h00000007);
      rc("bcr full", 7'h00, 32'h0000783c);
      wr(7'h20, 32'h0003fffe);
      for (int i = 0; i < 9; i++)
         rc("sample", 7'h30, {8'h5a, 16'h0000, i[7:0]});
      rc("drained", 7'h30, 32'h00000000);
      rc("fill 0", 7'h28, 32'h00000000);
      results();
   end
endmodule
`default_nettype wire
